// ==== rtl/aol_device.sv ====
// Purpose: output module end: decode, latch, gate eight stages
// Assumes: link inputs synchronous to clk
// Notes:   strobe acts on its rising edge only
`default_nettype none
`include "aol_defines.svh"

module aol_device (
    // clock and reset
    input  wire logic                   clk,
    input  wire logic                   srst,
    // backplane link
    aol_if.dev                          lnk,
    // identity straps, latch clear and output disable
    input  wire logic [`AOL_ID_W-1:0]   module_id,
    input  wire logic                   latch_clear_n,
    input  wire logic                   all_outputs_disable,
    // supply and protection indications
    input  wire logic                   vic_above_thr,
    input  wire logic                   vs_low,
    input  wire logic [`AOL_STAGES-1:0] short_det,
    // stage drive
    output logic [`AOL_STAGES-1:0]      stage_on,
    // alarm outputs, open collector
    output logic                        supply_alarm_internal_out,
    output logic                        supply_alarm_internal_oe_n,
    output logic                        supply_alarm_external_out,
    output logic                        supply_alarm_external_oe_n
);

    // ----------------------------------------
    // decode
    // ----------------------------------------
    function automatic logic id_match(
        input logic [`AOL_ADDR_W-1:0] a,
        input logic [`AOL_ID_W-1:0]   id
    );
        id_match = (a[`AOL_ID_MSB:`AOL_ID_LSB] == id);
    endfunction

    // group named by the group bit of the address
    function automatic logic grp_hit(
        input logic [`AOL_ADDR_W-1:0] a,
        input int                     g
    );
        grp_hit = (a[`AOL_GRP_BIT] == g[0]);
    endfunction

    localparam logic [`AOL_STAGES-1:0] LATCH_RST = `AOL_LATCH_RST;

    aol_pkg::aol_dev_t q;
    aol_pkg::aol_dev_t d;
    aol_pkg::aol_dev_t rst_val;

    logic                   sel;
    logic                   strobe_rise;
    logic                   store;
    logic                   clear_all;
    logic                   block_all;
    logic [`AOL_STAGES-1:0] gated;
    logic [`AOL_STAGES-1:0] latch_nxt;
    logic [1:0]             grp_wr;
    logic                   prd_set;
    logic                   def_set;
    logic                   def_clr;
    logic                   alarm_low;

    always_comb begin
        rst_val             = '0;
        rst_val.latch       = `AOL_LATCH_RST;
        rst_val.prd_oe_n    = 1'b1;
        rst_val.def_oe_n    = 1'b1;
        rst_val.ali_oe_n    = 1'b1;
        rst_val.ale_oe_n    = 1'b1;
    end

    // ----------------------------------------
    // select and store strobe
    // ----------------------------------------
    // identity straps only, no other source
    assign sel = lnk.address_valid
               && id_match(lnk.addr, module_id);

    assign strobe_rise = lnk.store_strobe && !q.strobe_prev;

    // store only in the i/o phase of the cycle
    assign store = sel && strobe_rise
                 && (lnk.phase_control == `AOL_PHC_IO);

    // ----------------------------------------
    // clear and block
    // ----------------------------------------
    // power-on reset and latch clear both empty the latches
    assign clear_all = !latch_clear_n
                     || !lnk.power_on_reset_n;

    // disable and low stage supply act on all stages at once
    assign block_all = all_outputs_disable
                     || vs_low;

    // ----------------------------------------
    // group write enables
    // ----------------------------------------
    genvar gg;
    generate
        for (gg = 0; gg < 2; gg++) begin : g_group
            // the store reaches one group of four stages
            assign grp_wr[gg] = store
                              && grp_hit(lnk.addr, gg);
        end
    endgenerate

    // ----------------------------------------
    // per-stage latch and gating
    // ----------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < `AOL_STAGES; gi++) begin : g_stage
            // clear and power-on reset win over a store
            assign latch_nxt[gi] = clear_all ? LATCH_RST[gi]
                                 : grp_wr[gi / `AOL_NIB_W]
                                 ? lnk.data_nibble[gi % `AOL_NIB_W]
                                 : q.latch[gi];
            // latch kept, so stage returns when short clears
            assign gated[gi] = q.latch[gi] && !block_all
                             && !short_det[gi];
        end
    endgenerate

    // ----------------------------------------
    // handshake terms
    // ----------------------------------------
    // prepare-done pulls low while addressed and valid
    assign prd_set = sel;

    // exchange-done set by a store, held until valid drops
    assign def_set = store;
    assign def_clr = !lnk.address_valid;

    // ----------------------------------------
    // alarm terms
    // ----------------------------------------
    // line pulled low means the converter input is healthy
    assign alarm_low = vic_above_thr;

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        d             = q;
        d.strobe_prev = lnk.store_strobe;

        // latches from the per-stage logic
        d.latch = latch_nxt;

        // stage view follows this cycle's gating
        d.stage = gated;

        // released unless addressed and valid
        d.prd_oe_n = !prd_set;

        // release wins: a store needs valid anyway
        if (def_clr) begin
            d.def_oe_n = 1'b1;
        end else if (def_set) begin
            d.def_oe_n = 1'b0;
        end

        // both alarm lines from one source
        d.ali_oe_n = !alarm_low;
        d.ale_oe_n = !alarm_low;

        if (srst) begin
            d = rst_val;
        end
    end

    always_ff @(posedge clk) begin
        q <= d;
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    // a driven open-collector line always sits at zero
    logic oc_zero_q;

    always_ff @(posedge clk) begin
        oc_zero_q <= 1'b0;
    end

    assign stage_on                   = q.stage;

    // ----------------------------------------
    // link returns, open collector
    // ----------------------------------------
    assign lnk.prepare_done_out       = oc_zero_q;
    assign lnk.prepare_done_oe_n      = q.prd_oe_n;
    assign lnk.exchange_done_out      = oc_zero_q;
    assign lnk.exchange_done_oe_n     = q.def_oe_n;

    // ----------------------------------------
    // alarm lines, open collector
    // ----------------------------------------
    assign supply_alarm_internal_out  = oc_zero_q;
    assign supply_alarm_internal_oe_n = q.ali_oe_n;
    assign supply_alarm_external_out  = oc_zero_q;
    assign supply_alarm_external_oe_n = q.ale_oe_n;

endmodule

`default_nettype wire

// ==== pkg/aol_defines.svh ====
// Purpose: constants of the addressed output latch, both ends
// Assumes: 200 MHz clock, one clock domain
// Notes:   timing list below, in ns and cycles
`ifndef AOL_DEFINES_SVH
`define AOL_DEFINES_SVH

// ----------------------------------------
// widths and fields
// ----------------------------------------
`define AOL_ADDR_W      11
`define AOL_ID_W        10
`define AOL_NIB_W       4
`define AOL_STAGES      8
`define AOL_PHC_W       2
`define AOL_GRP_BIT     0
`define AOL_ID_LSB      1
`define AOL_ID_MSB      10

// ----------------------------------------
// codes and reset values
// ----------------------------------------
`define AOL_PHC_IDLE    2'h0
`define AOL_PHC_IO      2'h3
`define AOL_LATCH_RST   8'h00

// ----------------------------------------
// timing
// ----------------------------------------
`define AOL_CLK_NS      5
`define AOL_POR_NS      1000
`define AOL_POR_CYC     ((`AOL_POR_NS + `AOL_CLK_NS - 1) / `AOL_CLK_NS)
`define AOL_STB_NS      20
`define AOL_STB_CYC     ((`AOL_STB_NS + `AOL_CLK_NS - 1) / `AOL_CLK_NS)
`define AOL_TMO_NS      200
`define AOL_TMO_CYC     (`AOL_TMO_NS / `AOL_CLK_NS)
`define AOL_CNT_W       8

`endif

// ==== pkg/aol_pkg.sv ====
// Purpose: types of the addressed output latch
// Assumes: aol_defines.svh on the include path
// Notes:   state of each end is one packed struct
`default_nettype none
`include "aol_defines.svh"

package aol_pkg;

    // ----------------------------------------
    // device state
    // ----------------------------------------
    typedef struct packed {
        logic [`AOL_STAGES-1:0] latch;
        logic [`AOL_STAGES-1:0] stage;
        logic                   strobe_prev;
        logic                   prd_oe_n;
        logic                   def_oe_n;
        logic                   ali_oe_n;
        logic                   ale_oe_n;
    } aol_dev_t;

    // ----------------------------------------
    // host state
    // ----------------------------------------
    typedef enum logic [2:0] {
        AOL_POR, AOL_IDLE, AOL_SETUP, AOL_WAIT_PRF,
        AOL_STROBE, AOL_WAIT_DEF, AOL_RELEASE
    } aol_hst_st_t;

    typedef struct packed {
        aol_hst_st_t               st;
        logic [`AOL_CNT_W-1:0]     cnt;
        logic [`AOL_ADDR_W-1:0]    addr;
        logic [`AOL_NIB_W-1:0]     nibble;
        logic [`AOL_PHC_W-1:0]     phase;
        logic                      valid;
        logic                      strobe;
        logic                      por_n;
        logic                      ready;
        logic                      done;
        logic                      error;
    } aol_hst_t;

endpackage

`default_nettype wire

// ==== pkg/aol_if.sv ====
// Purpose: backplane link between processor and output latch
// Assumes: open-collector lines resolved here
// Notes:   oe_n low means the line is pulled low
`default_nettype none
`include "aol_defines.svh"

interface aol_if;
    // processor driven
    logic [`AOL_ADDR_W-1:0] addr;
    logic [`AOL_NIB_W-1:0]  data_nibble;
    logic                   store_strobe;
    logic [`AOL_PHC_W-1:0]  phase_control;
    logic                   address_valid;
    logic                   power_on_reset_n;
    // open-collector returns
    logic                   prepare_done_out;
    logic                   prepare_done_oe_n;
    logic                   exchange_done_out;
    logic                   exchange_done_oe_n;
    // resolved wire levels, pulled up when released
    logic                   prepare_done_n;
    logic                   exchange_done_n;

    assign prepare_done_n  = prepare_done_oe_n ? 1'b1 : prepare_done_out;
    assign exchange_done_n = exchange_done_oe_n ? 1'b1 : exchange_done_out;

    modport dev (
        input  addr, data_nibble, store_strobe, phase_control,
        input  address_valid, power_on_reset_n,
        output prepare_done_out, prepare_done_oe_n,
        output exchange_done_out, exchange_done_oe_n
    );

    modport host (
        output addr, data_nibble, store_strobe, phase_control,
        output address_valid, power_on_reset_n,
        input  prepare_done_n, exchange_done_n
    );
endinterface

`default_nettype wire

// ==== rtl/aol_host.sv ====
// Purpose: processor end: power-on reset and addressed stores
// Assumes: one command at a time
// Notes:   timeout on prepare-done or exchange-done gives error
`default_nettype none
`include "aol_defines.svh"

module aol_host (
    // clock and reset
    input  wire logic                   clk,
    input  wire logic                   srst,
    // backplane link
    aol_if.host                         lnk,
    // command port
    input  wire logic                   cmd_valid,
    input  wire logic [`AOL_ADDR_W-1:0] cmd_addr,
    input  wire logic [`AOL_NIB_W-1:0]  cmd_data,
    output logic                        cmd_ready,
    output logic                        rsp_done,
    output logic                        rsp_error
);

    localparam logic [`AOL_CNT_W-1:0] POR_CYC = `AOL_CNT_W'(`AOL_POR_CYC);
    localparam logic [`AOL_CNT_W-1:0] STB_CYC = `AOL_CNT_W'(`AOL_STB_CYC);
    localparam logic [`AOL_CNT_W-1:0] TMO_CYC = `AOL_CNT_W'(`AOL_TMO_CYC);

    aol_pkg::aol_hst_t q;
    aol_pkg::aol_hst_t d;

    always_comb begin
        d       = q;
        d.done  = 1'b0;
        d.error = 1'b0;
        d.cnt   = q.cnt + `AOL_CNT_W'(1);
        unique case (q.st)
            aol_pkg::AOL_POR: begin
                // hold power-on reset low after switch-on
                if (q.cnt == POR_CYC - `AOL_CNT_W'(1)) begin
                    d.por_n = 1'b1;
                    d.ready = 1'b1;
                    d.st    = aol_pkg::AOL_IDLE;
                end
            end
            aol_pkg::AOL_IDLE: begin
                if (cmd_valid) begin
                    d.addr   = cmd_addr;
                    d.nibble = cmd_data;
                    d.phase  = `AOL_PHC_IO;
                    d.ready  = 1'b0;
                    d.st     = aol_pkg::AOL_SETUP;
                end
            end
            aol_pkg::AOL_SETUP: begin
                // address settled one cycle before valid
                d.valid = 1'b1;
                d.cnt   = '0;
                d.st    = aol_pkg::AOL_WAIT_PRF;
            end
            aol_pkg::AOL_WAIT_PRF: begin
                if (!lnk.prepare_done_n) begin
                    d.strobe = 1'b1;
                    d.cnt    = '0;
                    d.st     = aol_pkg::AOL_STROBE;
                end else if (q.cnt == TMO_CYC) begin
                    d.error = 1'b1;
                    d.st    = aol_pkg::AOL_RELEASE;
                end
            end
            aol_pkg::AOL_STROBE: begin
                if (q.cnt == STB_CYC - `AOL_CNT_W'(1)) begin
                    d.strobe = 1'b0;
                    d.cnt    = '0;
                    d.st     = aol_pkg::AOL_WAIT_DEF;
                end
            end
            aol_pkg::AOL_WAIT_DEF: begin
                if (!lnk.exchange_done_n) begin
                    d.done = 1'b1;
                    d.st   = aol_pkg::AOL_RELEASE;
                end else if (q.cnt == TMO_CYC) begin
                    d.error = 1'b1;
                    d.st    = aol_pkg::AOL_RELEASE;
                end
            end
            aol_pkg::AOL_RELEASE: begin
                d.valid = 1'b0;
                d.phase = `AOL_PHC_IDLE;
                d.ready = 1'b1;
                d.st    = aol_pkg::AOL_IDLE;
            end
            default: begin
                d.st = aol_pkg::AOL_IDLE;
            end
        endcase
        if (srst) begin
            d       = '0;
            d.st    = aol_pkg::AOL_POR;
            d.phase = `AOL_PHC_IDLE;
        end
    end

    always_ff @(posedge clk) begin
        q <= d;
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign lnk.addr             = q.addr;
    assign lnk.data_nibble      = q.nibble;
    assign lnk.store_strobe     = q.strobe;
    assign lnk.phase_control    = q.phase;
    assign lnk.address_valid    = q.valid;
    assign lnk.power_on_reset_n = q.por_n;
    assign cmd_ready            = q.ready;
    assign rsp_done             = q.done;
    assign rsp_error            = q.error;

endmodule

`default_nettype wire

// ==== dv/aol_sva.sv ====
// Purpose: link checks between processor end and output latch end
// Assumes: one clock domain, srst synchronous active high
// Notes:   watches the interface wires and the identity straps
`default_nettype none
`include "aol_defines.svh"

module aol_sva (
    // clock and reset
    input  wire logic                   clk,
    input  wire logic                   srst,
    // link wires and straps
    input  wire logic [`AOL_ADDR_W-1:0] addr,
    input  wire logic [`AOL_PHC_W-1:0]  phase_control,
    input  wire logic                   store_strobe,
    input  wire logic                   address_valid,
    input  wire logic                   power_on_reset_n,
    input  wire logic                   prepare_done_oe_n,
    input  wire logic                   exchange_done_oe_n,
    input  wire logic [`AOL_ID_W-1:0]   module_id
);
    timeunit 1ns;
    timeprecision 100ps;

    logic hit;

    assign hit = address_valid
               && addr[`AOL_ID_MSB:`AOL_ID_LSB] == module_id;

    default clocking @(posedge clk); endclocking
    default disable iff (srst);

    // ----------------------------------------
    // sequences
    // ----------------------------------------
    sequence store_s;
        (store_strobe && !$past(store_strobe)
         && phase_control == `AOL_PHC_IO) ##0 hit;
    endsequence

    sequence strobe_s;
        store_strobe [*4] ##1 !store_strobe;
    endsequence

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    prd_on_match_a: assert property (hit |=> !prepare_done_oe_n)
        else $error("prepare-done missing after address match");
    prd_cause_a: assert property (!prepare_done_oe_n |-> $past(hit))
        else $error("prepare-done without matching address");
    def_on_store_a: assert property (store_s |=> !exchange_done_oe_n)
        else $error("exchange-done missing after store");
    def_cause_a: assert property ($fell(exchange_done_oe_n)
        |-> $past(store_strobe) && $past(hit))
        else $error("exchange-done without a store");
    def_holds_a: assert property (!exchange_done_oe_n
        && address_valid |=> !exchange_done_oe_n)
        else $error("exchange-done dropped while valid");
    done_release_a: assert property (!address_valid
        |=> prepare_done_oe_n && exchange_done_oe_n)
        else $error("handshake outputs held without valid");
    strobe_width_a: assert property ($rose(store_strobe) |-> strobe_s)
        else $error("store strobe width wrong");
    strobe_order_a: assert property ($rose(store_strobe)
        |-> hit && !prepare_done_oe_n && phase_control == `AOL_PHC_IO)
        else $error("store strobe before handshake");
    addr_stable_a: assert property (address_valid
        && $past(address_valid) |-> $stable(addr))
        else $error("address moved while valid");
    por_hold_a: assert property ($fell(srst) |-> !power_on_reset_n [*8])
        else $error("power-on reset released too early");
endmodule

`default_nettype wire

// ==== dv/addressed_output_latch_tb.sv ====
// Purpose: self-checking bench, processor end facing output latch end
// Assumes: 200 MHz clock, srst held 6 cycles
// Notes:   stimulus from a 16-bit shift register seeded with 20
`default_nettype none
`include "aol_defines.svh"

module addressed_output_latch_tb;
    timeunit 1ns;
    timeprecision 100ps;

    logic                   clk, srst, cmd_valid, cmd_ready;
    logic                   rsp_done, rsp_error, latch_clear_n;
    logic [`AOL_ADDR_W-1:0] cmd_addr;
    logic [`AOL_NIB_W-1:0]  cmd_data;
    logic [`AOL_ID_W-1:0]   module_id;
    logic                   all_outputs_disable, vic_above_thr, vs_low;
    logic [7:0]             short_det, stage_on, exp_latch;
    logic                   ali_out, ali_oe_n, ale_out, ale_oe_n;
    logic [15:0]            lfsr;
    int                     error_cnt, checks_done, cyc;

    aol_if lnk ();
    aol_host aol_host_i (.clk, .srst, .lnk(lnk), .cmd_valid, .cmd_addr,
        .cmd_data, .cmd_ready, .rsp_done, .rsp_error);
    aol_device aol_device_i (.clk, .srst, .lnk(lnk), .module_id,
        .latch_clear_n, .all_outputs_disable, .vic_above_thr, .vs_low,
        .short_det, .stage_on, .supply_alarm_internal_out(ali_out),
        .supply_alarm_internal_oe_n(ali_oe_n),
        .supply_alarm_external_out(ale_out),
        .supply_alarm_external_oe_n(ale_oe_n));
    aol_sva aol_sva_i (.clk, .srst, .addr(lnk.addr),
        .phase_control(lnk.phase_control), .store_strobe(lnk.store_strobe),
        .address_valid(lnk.address_valid),
        .power_on_reset_n(lnk.power_on_reset_n),
        .prepare_done_oe_n(lnk.prepare_done_oe_n),
        .exchange_done_oe_n(lnk.exchange_done_oe_n), .module_id);

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    function automatic logic [7:0] exp_stage();
        return exp_latch & ~short_det & {8{!(all_outputs_disable || vs_low)}};
    endfunction

    task automatic check(input string what, input logic [31:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic store(input logic [10:0] a, input logic [3:0] d);
        int   n;
        logic hit;
        for (n = 0; n < 400 && cmd_ready !== 1'b1; n++) @(negedge clk);
        hit = (a[10:1] === module_id);
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_addr  <= a;
        cmd_data  <= d;
        @(posedge clk);
        cmd_valid <= 1'b0;
        for (n = 0; n < 200 && !(rsp_done === 1'b1 || rsp_error === 1'b1);
             n++) @(negedge clk);
        check("rsp_done", rsp_done, hit);
        check("rsp_error", rsp_error, !hit);
        if (hit)
            exp_latch[a[0]*4 +: 4] = d;
        repeat (2) @(negedge clk);
        check("stage_on", stage_on, exp_stage());
    endtask

    // ----------------------------------------
    // clock, timeout, sequence
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    always @(posedge clk) begin
        cyc++;
        if (cyc == 10000) begin
            error_cnt++;
            final_report();
        end
    end

    initial begin
        {cmd_valid, cmd_addr, cmd_data, all_outputs_disable, vs_low} = '0;
        {short_det, exp_latch} = '0;
        latch_clear_n = 1'b1;
        vic_above_thr = 1'b1;
        module_id = 10'h2a5;
        lfsr = 16'h0014;
        srst = 1'b1;
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        store({10'h2a5, 1'b0}, 4'ha);
        store({10'h2a5, 1'b1}, 4'h5);
        store({10'h2a4, 1'b1}, 4'hf);
        repeat (12) begin
            lfsr = lfsr_next(lfsr);
            store({lfsr[2] ? module_id : lfsr[15:6], lfsr[0]}, lfsr[11:8]);
        end
        $display("test stores done");
        for (int i = 0; i < 5; i++) begin
            lfsr = lfsr_next(lfsr);
            @(posedge clk);
            all_outputs_disable <= (i == 1);
            vs_low <= (i == 2);
            short_det <= (i == 3) ? lfsr[7:0] : 8'h00;
            repeat (3) @(negedge clk);
            check("stage_on", stage_on, exp_stage());
        end
        for (int i = 0; i < 2; i++) begin
            @(posedge clk);
            vic_above_thr <= i[0];
            repeat (3) @(negedge clk);
            check("alarm_int", ali_oe_n, !i[0]);
            check("alarm_ext", ale_oe_n, !i[0]);
            check("alarm_int_level", ali_out, 1'b0);
            check("alarm_ext_level", ale_out, 1'b0);
        end
        $display("test gating and alarms done");
        store({module_id, 1'b0}, 4'hf);
        @(posedge clk);
        latch_clear_n <= 1'b0;
        repeat (2) @(posedge clk);
        latch_clear_n <= 1'b1;
        exp_latch = 8'h00;
        repeat (3) @(negedge clk);
        check("stage_on", stage_on, 8'h00);
        store({module_id, 1'b1}, 4'h9);
        @(posedge clk);
        module_id <= 10'h1c3;
        @(negedge clk);
        store({10'h2a5, 1'b0}, 4'h3);
        store({10'h1c3, 1'b0}, 4'h3);
        $display("test clear and identity done");
        @(posedge clk);
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        exp_latch = 8'h00;
        repeat (20) @(negedge clk);
        check("stage_on", stage_on, 8'h00);
        check("cmd_ready", cmd_ready, 1'b0);
        store({module_id, 1'b1}, 4'h6);
        $display("test second reset done");
        final_report();
    end
endmodule

`default_nettype wire
